// *** pkg/lvd_consts.svh ***
`ifndef LVD_CONSTS_SVH
`define LVD_CONSTS_SVH
// Register byte offsets
`define LVD_CTRL_OFF 12'h000
`define LVD_STAT_OFF 12'h004
// Control and status register fields
`define LVD_DET_EN_BIT 7
`define LVD_SEL_BIT 3
`define LVD_RST_EN_BIT 2
`define LVD_FALL_EN_BIT 1
`define LVD_RISE_EN_BIT 0
`define LVD_CTRL_RSVD 8'h70
`define LVD_STAT_RSVD 8'hfc
`define LVD_FALL_FLAG_BIT 1
`define LVD_RISE_FLAG_BIT 0
// Reset release prescaler length in system clocks
`define LVD_RELEASE_CYCLES 131072
`endif

// *** pkg/lvd_pkg.sv ***
`default_nettype none
package lvd_pkg;
  // Reset release sequencer states
  typedef enum logic [1:0] {LVD_HOLD, LVD_COUNT, LVD_RUN} lvd_rst_state_t;
  // Trip level choice
  typedef enum logic {LVD_LEVEL_LOW, LVD_LEVEL_HIGH} lvd_level_t;
endpackage
`default_nettype wire

// *** logic/lvd_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; change counts when stages two and three agree
module lvd_sync
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage_ff;
  // Shift chain; stage 0 only feeds stage 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_ff <= 3'h0;
    else
      stage_ff <= {stage_ff[1:0], async_in};
  end
  // Output only moves when the two later stages agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_out <= 1'b0;
    else if (stage_ff[1] == stage_ff[2])
      sync_out <= stage_ff[2];
  end
endmodule
`default_nettype wire

// *** logic/lvd_release.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lvd_consts.svh"
// Internal reset release prescaler: counts after the cause clears
module lvd_release
#(
  parameter int RELEASE_CYCLES = `LVD_RELEASE_CYCLES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Synchronised reset cause, high while reset must be held
  input wire logic hold_req,
  // Internal chip reset, active low
  output logic chip_rst_n
);
  import lvd_pkg::*;
  lvd_rst_state_t state_ff;
  logic [17:0] cnt_ff;
  // Hold while cause stands, then count, then run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= LVD_HOLD;
      cnt_ff <= 18'h0;
    end
    else if (hold_req)
    begin
      state_ff <= LVD_HOLD;
      cnt_ff <= 18'h0;
    end
    else
    begin
      unique case (state_ff)
        LVD_HOLD:
        begin
          state_ff <= LVD_COUNT;
          cnt_ff <= 18'h0;
        end
        LVD_COUNT:
        begin
          // Release after the full count
          if (cnt_ff == 18'(RELEASE_CYCLES - 1))
            state_ff <= LVD_RUN;
          cnt_ff <= cnt_ff + 18'h1;
        end
        LVD_RUN:
          state_ff <= LVD_RUN;
      endcase
    end
  end
  // Registered reset output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chip_rst_n <= 1'b0;
    else
      chip_rst_n <= (state_ff == LVD_RUN) && !hold_req;
  end
  rel_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    hold_req |=> !chip_rst_n) else $error("reset not held");
endmodule
`default_nettype wire

// *** logic/lvd_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lvd_consts.svh"
module lvd_ctrl
#(
  parameter int RELEASE_CYCLES = `LVD_RELEASE_CYCLES
)
(
  // APB clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // Watchdog reset request, active high, synchronous
  input wire logic watchdog_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analogue comparators, asynchronous, high when supply below level; above_rise_lvl high when supply above level
  input wire logic below_reset_lvl,
  input wire logic below_fall_lvl,
  input wire logic above_rise_lvl,
  // Reset pin level, high once capacitor charged
  input wire logic external_reset_pin,
  // Analogue controls
  output logic detect_active,
  output var lvd_pkg::lvd_level_t trip_level,
  // Interrupts and chip reset
  output logic fall_irq,
  output logic rise_irq,
  output logic undervolt_rst_req,
  output logic chip_rst_n
);
  import lvd_pkg::*;
  logic [7:0] ctrl_ff; // Control register, writable bits only
  logic fall_flag_ff; // Supply fell
  logic rise_flag_ff; // Supply recovered
  logic fall_seen_ff; // Read-as-one seen for fall flag
  logic rise_seen_ff; // Read-as-one seen for rise flag
  logic armed_ff; // Fall occurred, rise may follow
  logic below_rst_s; // Synchronised comparators
  logic below_fall_s;
  logic above_rise_s;
  logic pin_high_s;
  logic below_fall_d_ff; // Previous for edge detect
  logic above_rise_d_ff;
  logic wr_stb; // Write access phase
  logic rd_stb; // Read access phase
  logic hit_ctrl;
  logic hit_stat;
  logic fall_edge;
  logic rise_edge;
  logic det_en;

  // Address decode helper
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  // Comparator synchronisers
  lvd_sync u_sync_rst (.pclk(pclk), .presetn(presetn), .async_in(below_reset_lvl),
    .sync_out(below_rst_s));
  lvd_sync u_sync_fall (.pclk(pclk), .presetn(presetn), .async_in(below_fall_lvl),
    .sync_out(below_fall_s));
  lvd_sync u_sync_rise (.pclk(pclk), .presetn(presetn), .async_in(above_rise_lvl),
    .sync_out(above_rise_s));
  lvd_sync u_sync_pin (.pclk(pclk), .presetn(presetn), .async_in(external_reset_pin),
    .sync_out(pin_high_s));

  // Bus strobes; zero wait states
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_stb = psel && penable && pwrite;
  assign rd_stb = psel && penable && !pwrite;
  assign hit_ctrl = addr_is(paddr, `LVD_CTRL_OFF);
  assign hit_stat = addr_is(paddr, `LVD_STAT_OFF);

  // Detector gating; every other enable is ignored while off
  assign det_en = ctrl_ff[`LVD_DET_EN_BIT];
  assign detect_active = det_en;
  assign trip_level = lvd_level_t'(ctrl_ff[`LVD_SEL_BIT]);

  // Control register: presetn is the power-on reset; watchdog also clears.
  // The undervoltage reset never reaches here, so settings persist
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= 8'h00;
    else if (watchdog_rst)
      ctrl_ff <= 8'h00;
    else if (wr_stb && hit_ctrl)
      ctrl_ff <= pwdata[7:0] & ~`LVD_CTRL_RSVD;
  end

  // Edge detectors on synchronised levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      below_fall_d_ff <= 1'b0;
      above_rise_d_ff <= 1'b0;
    end
    else
    begin
      below_fall_d_ff <= below_fall_s;
      above_rise_d_ff <= above_rise_s;
    end
  end
  assign fall_edge = det_en && below_fall_s && !below_fall_d_ff;
  assign rise_edge = det_en && above_rise_s && !above_rise_d_ff;

  // Read-as-one tracking for the clear protocol
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fall_seen_ff <= 1'b0;
      rise_seen_ff <= 1'b0;
    end
    else if (rd_stb && hit_stat)
    begin
      fall_seen_ff <= fall_flag_ff;
      rise_seen_ff <= rise_flag_ff;
    end
    else
    begin
      // A cleared flag forgets the read, so a fresh event needs a fresh read
      fall_seen_ff <= fall_seen_ff && fall_flag_ff;
      rise_seen_ff <= rise_seen_ff && rise_flag_ff;
    end
  end

  // Fall flag; a set in the clear cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fall_flag_ff <= 1'b0;
    else if (!chip_rst_n)
      fall_flag_ff <= 1'b0;
    else if (fall_edge)
      fall_flag_ff <= 1'b1;
    else if (wr_stb && hit_stat && fall_seen_ff && !pwdata[`LVD_FALL_FLAG_BIT])
      fall_flag_ff <= 1'b0;
  end

  // Arming: fall with rise enable, disarmed by reset-level drop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      armed_ff <= 1'b0;
    else if (!det_en || below_rst_s)
      armed_ff <= 1'b0;
    else if (fall_edge && ctrl_ff[`LVD_RISE_EN_BIT])
      armed_ff <= 1'b1;
    else if (rise_edge)
      armed_ff <= 1'b0;
  end

  // Rise flag; set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rise_flag_ff <= 1'b0;
    else if (!chip_rst_n)
      rise_flag_ff <= 1'b0;
    else if (rise_edge && armed_ff)
      rise_flag_ff <= 1'b1;
    else if (wr_stb && hit_stat && rise_seen_ff && !pwdata[`LVD_RISE_FLAG_BIT])
      rise_flag_ff <= 1'b0;
  end

  // Interrupt requests stay up until the flag, its enable or the detector enable clears
  assign fall_irq = det_en && fall_flag_ff && ctrl_ff[`LVD_FALL_EN_BIT];
  assign rise_irq = det_en && rise_flag_ff && ctrl_ff[`LVD_RISE_EN_BIT];

  // Undervoltage reset request
  assign undervolt_rst_req = det_en && ctrl_ff[`LVD_RST_EN_BIT] && below_rst_s;

  // Chip reset held by low pin or undervoltage, released after prescaler
  lvd_release #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_release (
    .pclk(pclk),
    .presetn(presetn),
    .hold_req(undervolt_rst_req || !pin_high_s),
    .chip_rst_n(chip_rst_n)
  );

  // Read data, registered; unmapped reads give zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      if (addr_is(paddr, `LVD_CTRL_OFF))
        prdata <= {24'h0, ctrl_ff | `LVD_CTRL_RSVD};
      else if (addr_is(paddr, `LVD_STAT_OFF))
        prdata <= {24'h0, `LVD_STAT_RSVD | {6'h0, fall_flag_ff, rise_flag_ff}};
      else
        prdata <= 32'h0;
    end
  end

  // Reserved control bits read back as one
  ctrl_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 rd_stb && hit_ctrl && $past(psel && !penable) |-> prdata[6:4] == 3'h7)
    else $error("reserved bits not one");

  // Reserved control bits never stored
  ctrl_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_ff[6:4] == 3'h0)
    else $error("fixed bits stored");

  // Status fixed bits read back as one
  stat_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_stb && hit_stat && $past(psel && !penable) |-> prdata[7:2] == 6'h3f)
    else $error("status fixed bits wrong");

  // Standby silences every output request
  ctrl_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !det_en |-> !fall_irq && !rise_irq && !undervolt_rst_req)
    else $error("active while detector off");

  // No fall flag can be raised in standby
  fall_det_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fall_flag_ff) |-> $past(det_en))
    else $error("fall flag in standby");

  // Reset request needs both enables and a low supply
  uv_req_a: assert property (@(posedge pclk) disable iff (!presetn)
    undervolt_rst_req == (det_en && ctrl_ff[2] && below_rst_s))
    else $error("reset request wrong");

  // Reset enable off means no request at all
  rst_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_ff[2] |-> !undervolt_rst_req)
    else $error("reset while disabled");

  // Fall interrupt is flag and enable
  irq_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    fall_irq |-> fall_flag_ff && ctrl_ff[1])
    else $error("fall irq wrong");

  // Rise interrupt is flag and enable
  rise_and_a: assert property (@(posedge pclk) disable iff (!presetn)
    rise_irq |-> rise_flag_ff && ctrl_ff[0])
    else $error("rise irq wrong");

  // Watchdog clears the settings
  wdt_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_rst |=> ctrl_ff == 8'h00)
    else $error("watchdog no clear");

  // A qualified fall edge always sets the flag
  fall_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    fall_edge && chip_rst_n |=> fall_flag_ff)
    else $error("fall flag missed");

  // Flag sets only from the synchronised level
  fall_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fall_flag_ff) |-> $past(below_fall_s))
    else $error("fall flag unsynced");

  // Fall flag leaves only by chip reset or the read-then-write clear
  fall_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fall_flag_ff) |-> $past(!chip_rst_n || (wr_stb && hit_stat && fall_seen_ff)))
    else $error("fall flag lost");

  // Rise flag leaves only by chip reset or the read-then-write clear
  rise_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(rise_flag_ff) |-> $past(!chip_rst_n || (wr_stb && hit_stat && rise_seen_ff)))
    else $error("rise flag lost");

  // A stale read must not clear a later event
  seen_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    !fall_flag_ff |=> !fall_seen_ff)
    else $error("stale fall read");

  // Rise flag needs an armed fall first
  rise_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rise_flag_ff) |-> $past(armed_ff))
    else $error("rise without fall");

  // Undervoltage request reaches the chip reset
  uv_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    undervolt_rst_req |-> ##2 !chip_rst_n)
    else $error("no chip reset");

  // Low reset pin holds the chip in reset
  pin_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_high_s |=> !chip_rst_n)
    else $error("reset pin ignored");
endmodule
`default_nettype wire

// *** sim/lvd_ana_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Supply comparators and reset pin; supply in tenths of a volt
module lvd_ana_model
(
  // Trip level chosen by the block
  input wire lvd_pkg::lvd_level_t trip_level,
  // Commanded supply and pin charge state
  input wire logic [7:0] vcc,
  input wire logic pin_charged,
  // Comparator and pin levels
  output logic below_reset_lvl,
  output logic below_fall_lvl,
  output logic above_rise_lvl,
  output logic external_reset_pin
);
  import lvd_pkg::*;
  // Reset threshold follows the select bit
  logic [7:0] trip_lvl;
  assign trip_lvl = (trip_level == LVD_LEVEL_HIGH) ? 8'h24 : 8'h17;
  // Raw comparisons; the block itself must mask them in standby
  assign below_reset_lvl = vcc < trip_lvl;
  assign below_fall_lvl = vcc < 8'h25;
  assign above_rise_lvl = vcc > 8'h28;
  // Pin rises once the capacitor has charged
  assign external_reset_pin = pin_charged;
endmodule
`default_nettype wire

// *** sim/tb_lvd_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lvd_consts.svh"
// Self-checking bench for the voltage detect control block
module tb_lvd_ctrl;
  import lvd_pkg::*;
  localparam int RC = 16;
  localparam logic [7:0] COMBO [5] = '{8'h00, 8'h8c, 8'h82, 8'h83, 8'h87};
  // Clock, resets and APB
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic watchdog_rst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Analogue side
  logic [7:0] vcc = 8'h32;
  logic pin_charged = 1'b0;
  logic below_reset_lvl, below_fall_lvl, above_rise_lvl, external_reset_pin;
  logic detect_active, fall_irq, rise_irq, undervolt_rst_req, chip_rst_n;
  lvd_level_t trip_level;
  // Bench state
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h5a894c70;
  logic [31:0] rd;
  logic [7:0] w;
  logic [7:0] cur = 8'h00; // Last control value written by set_ctrl
  logic rd_err; // Response code of the last transfer
  int n;
  // Free-running clock
  always #20 pclk = ~pclk;
  lvd_ctrl #(.RELEASE_CYCLES(RC)) i_lvd_ctrl (.pclk(pclk), .presetn(presetn),
    .watchdog_rst(watchdog_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .below_reset_lvl(below_reset_lvl), .below_fall_lvl(below_fall_lvl),
    .above_rise_lvl(above_rise_lvl), .external_reset_pin(external_reset_pin),
    .detect_active(detect_active), .trip_level(trip_level), .fall_irq(fall_irq),
    .rise_irq(rise_irq), .undervolt_rst_req(undervolt_rst_req), .chip_rst_n(chip_rst_n));
  lvd_ana_model i_lvd_ana_model (.trip_level(trip_level), .vcc(vcc),
    .pin_charged(pin_charged), .below_reset_lvl(below_reset_lvl),
    .below_fall_lvl(below_fall_lvl), .above_rise_lvl(above_rise_lvl),
    .external_reset_pin(external_reset_pin));
  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Control readback: bits six to four always set
  function automatic logic [7:0] ctrl_exp(input logic [7:0] v);
    return v | 8'h70;
  endfunction
  // Verdict and end of run
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // A bounded wait that ran out ends the run
  task automatic lim(input int k);
    if (k >= 400)
    begin
      err_total++;
      $display("FAIL %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  // One APB transfer; read data lands in rd
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 400);
    lim(k);
    rd = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Control write in the software order: enables drop first, detector settles first
  task automatic set_ctrl(input logic [7:0] v);
    if (cur[2:0] != 3'h0)
      apb(1'b1, `LVD_CTRL_OFF, {24'h0, cur & 8'hf8});
    if (v[7] && !cur[7])
    begin
      apb(1'b1, `LVD_CTRL_OFF, {24'h0, v & 8'hf8});
      repeat (1250) @(posedge pclk);
    end
    apb(1'b1, `LVD_CTRL_OFF, {24'h0, v});
    cur = v;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `LVD_CTRL_OFF, 32'h0);
    chk(rd[7:0], 8'h70, "ctrl reset");
    apb(1'b0, `LVD_STAT_OFF, 32'h0);
    chk(rd[7:0], 8'hfc, "status reset");
    apb(1'b0, 12'h0f0, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(rd_err, 1'b0, "no error response");
    chk(chip_rst_n, 1'b0, "held before pin");
    pin_charged <= 1'b1;
    for (n = 0; n < 400 && chip_rst_n !== 1'b1; n++) @(posedge pclk);
    lim(n);
    chk(n >= RC, 1'b1, "power-up release length");
    chk(n <= RC + 8, 1'b1, "power-up release late");
    // Permitted settings with junk in the fixed bits
    repeat (8)
    begin
      seed = lfsr(seed);
      w = COMBO[seed % 5] | (seed[15:8] & 8'h70);
      set_ctrl(w);
      apb(1'b0, `LVD_CTRL_OFF, 32'h0);
      chk(rd[7:0], ctrl_exp(w), "ctrl readback");
      chk(detect_active, w[7], "detector enable");
      chk(trip_level, w[3], "trip select");
    end
    // Fall then rise with both interrupts armed
    apb(1'b1, `LVD_CTRL_OFF, 32'h80);
    repeat (1250) @(posedge pclk);
    apb(1'b1, `LVD_CTRL_OFF, 32'h83);
    vcc <= 8'h23;
    for (n = 0; n < 400 && fall_irq !== 1'b1; n++) @(posedge pclk);
    lim(n);
    chk(rise_irq, 1'b0, "rise before recovery");
    chk(undervolt_rst_req, 1'b0, "reset not enabled");
    vcc <= 8'h2a;
    for (n = 0; n < 400 && rise_irq !== 1'b1; n++) @(posedge pclk);
    lim(n);
    apb(1'b0, `LVD_STAT_OFF, 32'h0);
    chk(rd[7:0], 8'hff, "both flags");
    apb(1'b1, `LVD_STAT_OFF, 32'h0);
    repeat (2) @(posedge pclk);
    chk({fall_irq, rise_irq}, 2'b00, "irqs cleared");
    // Clear without a prior read, then mask the enable
    apb(1'b1, `LVD_CTRL_OFF, 32'h82);
    vcc <= 8'h23;
    for (n = 0; n < 400 && fall_irq !== 1'b1; n++) @(posedge pclk);
    lim(n);
    apb(1'b1, `LVD_STAT_OFF, 32'h0);
    apb(1'b1, `LVD_CTRL_OFF, 32'h80);
    vcc <= 8'h2a;
    repeat (10) @(posedge pclk);
    chk(fall_irq, 1'b0, "masked by enable");
    apb(1'b0, `LVD_STAT_OFF, 32'h0);
    chk(rd[7:0], 8'hfe, "flag kept, no rise");
    apb(1'b1, `LVD_STAT_OFF, 32'h0);
    // Detector off ignores every other enable
    apb(1'b1, `LVD_CTRL_OFF, 32'h00);
    apb(1'b1, `LVD_CTRL_OFF, 32'h0f);
    vcc <= 8'h10;
    repeat (10) @(posedge pclk);
    chk({fall_irq, rise_irq, undervolt_rst_req, chip_rst_n}, 4'b0001, "standby");
    vcc <= 8'h32;
    // Undervoltage reset at the high level and timed release
    apb(1'b1, `LVD_CTRL_OFF, 32'h80);
    repeat (1250) @(posedge pclk);
    apb(1'b1, `LVD_CTRL_OFF, 32'h8c);
    vcc <= 8'h1e;
    for (n = 0; n < 400 && undervolt_rst_req !== 1'b1; n++) @(posedge pclk);
    lim(n);
    repeat (2) @(posedge pclk);
    chk(chip_rst_n, 1'b0, "undervoltage reset");
    vcc <= 8'h32;
    for (n = 0; n < 400 && chip_rst_n !== 1'b1; n++) @(posedge pclk);
    lim(n);
    chk(n >= RC, 1'b1, "release held");
    apb(1'b0, `LVD_CTRL_OFF, 32'h0);
    chk(rd[7:0], 8'hfc, "ctrl kept");
    // Watchdog clears the control register
    watchdog_rst <= 1'b1;
    @(posedge pclk);
    watchdog_rst <= 1'b0;
    apb(1'b0, `LVD_CTRL_OFF, 32'h0);
    chk(rd[7:0], 8'h70, "watchdog clear");
    wrap_up();
  end
endmodule
`default_nettype wire
